// ---- inc/sad_pkg.sv ----
// shared constants and types for the secure alias address decoder
`default_nettype none
package sad_pkg;
   // ****************************************************
   // address layout
   // ****************************************************
   localparam int ADDR_W      = 32;
   localparam int ALIAS_BIT   = 28;
   localparam int BUS_SEL_LSB = 29;
   localparam int BUS_SEL_W   = 3;
   localparam int OFS_W       = 28;

   localparam logic [2:0] BUS_CODE   = 3'h0;
   localparam logic [2:0] BUS_DATA   = 3'h1;
   localparam logic [2:0] BUS_PERIPH = 3'h2;

   // offsets below the alias bit, same for both aliases
   localparam logic [27:0] RAM_BASE   = 28'h0000000;
   localparam logic [27:0] RAM_END    = 28'h047FFFF;
   localparam logic [27:0] ROM_BASE   = 28'h3000000;
   localparam logic [27:0] ROM_END    = 28'h303FFFF;
   localparam logic [27:0] FLASH_BASE = 28'h8000000;
   localparam logic [27:0] FLASH_END  = 28'hFFFFFFF;
   localparam logic [27:0] DTCM_BASE  = 28'h4000000;
   localparam logic [27:0] DTCM_END   = 28'h400FFFF;
   localparam logic [27:0] ITCM_BASE  = 28'h4020000;
   localparam logic [27:0] ITCM_END   = 28'h402FFFF;
   localparam logic [27:0] LSP_BASE   = 28'h0000000;
   localparam logic [27:0] LSP_END    = 28'h007FFFF;
   localparam logic [27:0] HSP_BASE   = 28'h0100000;
   localparam logic [27:0] HSP_END    = 28'h015FFFF;

   // low-speed peripheral slots: 4 kB each, 64 of them
   localparam int SLOT_LSB   = 12;
   localparam int SLOT_W     = 6;
   localparam int SLOT_COUNT = 64;

   // upper bounds of the shared ram slave ports, ascending
   localparam int RAM_PORTS = 7;
   localparam logic [27:0] RAM_PORT_TOP [RAM_PORTS-1] = '{
      28'h0010000, 28'h0020000, 28'h0040000, 28'h0080000,
      28'h0100000, 28'h0200000};

   // checker granularity
   localparam int RANGES        = 32;
   localparam int RANGE_W       = 5;
   localparam int RANGE_LSB_DEF = 23;

   // master indices, lower index wins a shared slave port
   localparam int M_DATA  = 0;
   localparam int M_CODE  = 1;
   localparam int M_DSP   = 2;
   localparam int MASTERS = 3;

   // ****************************************************
   // types
   // ****************************************************
   typedef enum logic [1:0] {
      PERM_OPEN,
      PERM_SECURE,
      PERM_NSC,
      PERM_CLOSED
   } sad_perm_t;

   typedef enum logic [3:0] {
      TGT_NONE,
      TGT_RAM,
      TGT_ROM,
      TGT_FLASH,
      TGT_FLASH_NC,
      TGT_DTCM,
      TGT_ITCM,
      TGT_LSP,
      TGT_HSP
   } sad_tgt_t;

   typedef enum logic {
      RESP_OKAY,
      RESP_ERROR
   } sad_resp_t;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic              write;
      logic              nonsec;
      logic              instr;
   } sad_req_t;

   typedef struct packed {
      sad_tgt_t          tgt;
      logic [2:0]        ram_port;
      logic [SLOT_W-1:0] slot;
   } sad_route_t;

   typedef struct packed {
      logic             valid;
      logic             stall;
      sad_tgt_t         tgt;
      logic [2:0]       ram_port;
      logic [SLOT_W-1:0] slot;
      logic [OFS_W-1:0] offset;
      logic             secure;
      logic             bypass;
      sad_resp_t        resp;
   } sad_rsp_t;

   localparam sad_rsp_t RSP_RESET = '{
      valid: 1'b0, stall: 1'b0, tgt: TGT_NONE, ram_port: 3'h0, slot: 6'h00,
      offset: 28'h0000000, secure: 1'b0, bypass: 1'b0, resp: RESP_OKAY};
endpackage
`default_nettype wire

// ---- verilog/sad_checker.sv ----
// per-port access checker: permission of the addressed range against the access
`default_nettype none
module sad_checker
   import sad_pkg::*;
#(
   parameter int RANGE_LSB = RANGE_LSB_DEF
) (
   input  wire sad_req_t       req,     // access under test
   input  wire sad_perm_t [RANGES-1:0] perm, // permission of each range
   output logic                allow    // access may proceed
);
   // ****************************************************
   // elaboration check
   // ****************************************************
   if (RANGE_LSB < SLOT_LSB || RANGE_LSB + RANGE_W > ALIAS_BIT) begin : g_bad
      $error("sad_checker: range field must sit below the alias bit");
   end

   logic [RANGE_W-1:0] idx;
   sad_perm_t          p;
   logic               sec_alias;

   // ****************************************************
   // decision
   // ****************************************************
   assign idx       = req.addr[RANGE_LSB +: RANGE_W];
   assign p         = perm[idx];
   assign sec_alias = req.addr[ALIAS_BIT];

   always_comb begin
      allow = 1'b1;
      case (p)
         PERM_OPEN: begin
            allow = !(sec_alias && req.nonsec);
         end
         PERM_SECURE: begin
            allow = !req.nonsec;
         end
         PERM_NSC: begin
            // non-secure code may only enter through fetches
            allow = !req.nonsec || (req.instr && !req.write);
         end
         PERM_CLOSED: begin
            allow = 1'b0;
         end
         default: begin
            allow = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

// ---- verilog/sad_decoder.sv ----
// address decode, alias handling, checking and port arbitration for the bus fabric
`default_nettype none
// How it works
// - physical target ignores address bit 28, except dsp code-range accesses, which need it clear
// - bit 28 set means secure alias
// - code range: ram, boot rom, flash window
// - data range: ram, tightly coupled memory, dsp flash
// - peripheral range: high and low speed buses
// - low-speed area 512 kB, 64 4 kB slots
// - unmapped access faults processor, not dsp
// - checker per port over 32 ranges
// - whole ram on code and data bus
// - fetch and data on different ports concurrent
// - dsp ram path bypasses the matrix
// - checker decides kinds including non-secure callable
// - different slave ports served simultaneously
module sad_decoder
   import sad_pkg::*;
#(
   parameter int RANGE_LSB = RANGE_LSB_DEF
) (
   input  wire logic      sys_clk,    // system clock, 10 MHz
   input  wire logic      resetn,     // asynchronous reset, active low
   input  wire sad_req_t  req_data,   // processor data bus request
   input  wire sad_req_t  req_code,   // processor code bus request
   input  wire sad_req_t  req_dsp,    // dsp request
   input  wire sad_perm_t [RANGES-1:0] perm_data, // checker ranges, data port
   input  wire sad_perm_t [RANGES-1:0] perm_code, // checker ranges, code port
   input  wire sad_perm_t [RANGES-1:0] perm_dsp,  // checker ranges, dsp port
   output sad_rsp_t       rsp_data,   // routed answer, data bus
   output sad_rsp_t       rsp_code,   // routed answer, code bus
   output sad_rsp_t       rsp_dsp     // routed answer, dsp
);
   // ****************************************************
   // elaboration check
   // ****************************************************
   if (RANGE_LSB < SLOT_LSB || RANGE_LSB + RANGE_W > ALIAS_BIT) begin : g_bad
      $error("sad_decoder: range field must sit below the alias bit");
   end
   if (SLOT_COUNT != (1 << SLOT_W)) begin : g_bad_slot
      $error("sad_decoder: slot field does not match slot count");
   end

   // ****************************************************
   // decode helpers
   // ****************************************************
   function automatic logic in_rng(input logic [27:0] a, input logic [27:0] lo,
                                   input logic [27:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [2:0] ram_port_of(input logic [27:0] a);
      logic [2:0] n;
      n = 3'(RAM_PORTS - 1);
      for (int k = RAM_PORTS - 2; k >= 0; k--) begin
         if (a < RAM_PORT_TOP[k]) begin
            n = 3'(k);
         end
      end
      ram_port_of = n;
   endfunction

   function automatic sad_route_t decode(input logic [ADDR_W-1:0] addr,
                                         input int m);
      sad_route_t  r;
      logic [27:0] ofs;
      logic        cpu_data;
      r   = '{tgt: TGT_NONE, ram_port: 3'h0, slot: '0};
      ofs = addr[OFS_W-1:0];
      cpu_data = (m == M_DATA);
      case (addr[BUS_SEL_LSB +: BUS_SEL_W])
         BUS_CODE: begin
            if (m == M_CODE) begin
               if (in_rng(ofs, RAM_BASE, RAM_END)) begin
                  r.tgt = TGT_RAM;
               end else if (in_rng(ofs, ROM_BASE, ROM_END)) begin
                  r.tgt = TGT_ROM;
               end else if (in_rng(ofs, FLASH_BASE, FLASH_END)) begin
                  r.tgt = TGT_FLASH;
               end
            end else if (m == M_DSP && !addr[ALIAS_BIT]) begin
               if (in_rng(ofs, RAM_BASE, RAM_END)) begin
                  r.tgt = TGT_RAM;
               end else if (in_rng(ofs, FLASH_BASE, FLASH_END)) begin
                  r.tgt = TGT_FLASH;
               end
            end
         end
         BUS_DATA: begin
            if (cpu_data || m == M_DSP) begin
               if (in_rng(ofs, RAM_BASE, RAM_END)) begin
                  r.tgt = TGT_RAM;
               end else if (in_rng(ofs, DTCM_BASE, DTCM_END)) begin
                  r.tgt = TGT_DTCM;
               end else if (in_rng(ofs, ITCM_BASE, ITCM_END)) begin
                  r.tgt = TGT_ITCM;
               end else if (m == M_DSP && in_rng(ofs, FLASH_BASE, FLASH_END)) begin
                  r.tgt = TGT_FLASH_NC;
               end
            end
         end
         BUS_PERIPH: begin
            if (cpu_data || m == M_DSP) begin
               if (in_rng(ofs, LSP_BASE, LSP_END)) begin
                  r.tgt  = TGT_LSP;
                  r.slot = ofs[SLOT_LSB +: SLOT_W];
                  // upper half of the area holds no slot
                  if (ofs[SLOT_LSB + SLOT_W]) begin
                     r.tgt  = TGT_NONE;
                     r.slot = '0;
                  end
               end else if (in_rng(ofs, HSP_BASE, HSP_END)) begin
                  r.tgt = TGT_HSP;
               end
            end
         end
         default: begin
            r.tgt = TGT_NONE;
         end
      endcase
      if (r.tgt == TGT_RAM) begin
         r.ram_port = ram_port_of(ofs);
      end
      decode = r;
   endfunction

   // ****************************************************
   // per-master decode and check
   // ****************************************************
   sad_req_t              req   [MASTERS];
   sad_perm_t [RANGES-1:0] perm [MASTERS];
   sad_route_t            route [MASTERS];
   logic [MASTERS-1:0]    allow;
   logic [MASTERS-1:0]    bypass;
   logic [MASTERS-1:0]    grant;
   sad_rsp_t              rsp_nxt [MASTERS];
   sad_rsp_t              rsp_r   [MASTERS];

   assign req[M_DATA]  = req_data;
   assign req[M_CODE]  = req_code;
   assign req[M_DSP]   = req_dsp;
   assign perm[M_DATA] = perm_data;
   assign perm[M_CODE] = perm_code;
   assign perm[M_DSP]  = perm_dsp;

   for (genvar i = 0; i < MASTERS; i++) begin : g_port
      assign route[i] = decode(req[i].addr, i);

      sad_checker #(
         .RANGE_LSB (RANGE_LSB)
      ) u_chk (
         .req   (req[i]),
         .perm  (perm[i]),
         .allow (allow[i])
      );

      // dsp reaches shared ram on its own path, outside the matrix
      assign bypass[i] = (i == M_DSP) && (route[i].tgt == TGT_RAM);
   end

   // ****************************************************
   // slave port arbitration
   // ****************************************************
   function automatic logic same_port(input sad_route_t a, input sad_route_t b);
      same_port = (a.tgt == b.tgt) && (a.tgt != TGT_NONE) &&
                  ((a.tgt != TGT_RAM) || (a.ram_port == b.ram_port));
   endfunction

   always_comb begin
      for (int i = 0; i < MASTERS; i++) begin
         grant[i] = req[i].valid;
         // only a clash on one slave port serialises masters
         for (int j = 0; j < i; j++) begin
            if (req[j].valid && !bypass[i] && !bypass[j] &&
                allow[j] && allow[i] && same_port(route[i], route[j])) begin
               grant[i] = 1'b0;
            end
         end
      end
   end

   // ****************************************************
   // answer forming
   // ****************************************************
   always_comb begin
      for (int i = 0; i < MASTERS; i++) begin
         rsp_nxt[i]          = RSP_RESET;
         rsp_nxt[i].valid    = grant[i];
         rsp_nxt[i].stall    = req[i].valid && !grant[i];
         rsp_nxt[i].ram_port = route[i].ram_port;
         rsp_nxt[i].slot     = route[i].slot;
         rsp_nxt[i].offset   = req[i].addr[OFS_W-1:0];
         rsp_nxt[i].secure   = req[i].addr[ALIAS_BIT];
         rsp_nxt[i].bypass   = bypass[i];
         if (!allow[i]) begin
            rsp_nxt[i].tgt  = TGT_NONE;
            rsp_nxt[i].resp = RESP_ERROR;
         end else if (route[i].tgt == TGT_NONE) begin
            rsp_nxt[i].tgt  = TGT_NONE;
            // the dsp sees a harmless answer from empty space
            rsp_nxt[i].resp = (i == M_DSP) ? RESP_OKAY : RESP_ERROR;
         end else begin
            rsp_nxt[i].tgt  = route[i].tgt;
            rsp_nxt[i].resp = RESP_OKAY;
         end
      end
   end

   // ****************************************************
   // registered answers
   // ****************************************************
   for (genvar i = 0; i < MASTERS; i++) begin : g_reg
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            rsp_r[i] <= RSP_RESET;
         end else begin
            rsp_r[i] <= rsp_nxt[i];
         end
      end
   end

   assign rsp_data = rsp_r[M_DATA];
   assign rsp_code = rsp_r[M_CODE];
   assign rsp_dsp  = rsp_r[M_DSP];
endmodule
`default_nettype wire

// ---- test/sad_decoder_asserts.sv ----
// port-level assertions for the address decoder
`default_nettype none
module sad_decoder_asserts
   import sad_pkg::*;
#(
   parameter int RANGE_LSB = RANGE_LSB_DEF
) (
   input wire logic                    sys_clk,   // system clock
   input wire logic                    resetn,    // reset, active low
   input wire sad_req_t                req_data,  // data bus request
   input wire sad_req_t                req_code,  // code bus request
   input wire sad_req_t                req_dsp,   // dsp request
   input wire sad_perm_t [RANGES-1:0]  perm_data, // data port ranges
   input wire sad_perm_t [RANGES-1:0]  perm_code, // code port ranges
   input wire sad_perm_t [RANGES-1:0]  perm_dsp,  // dsp port ranges
   input wire sad_rsp_t                rsp_data,  // data bus answer
   input wire sad_rsp_t                rsp_code,  // code bus answer
   input wire sad_rsp_t                rsp_dsp    // dsp answer
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   alias_strip_a: assert property (
      req_data.valid |=> rsp_data.tgt == TGT_NONE ||
      rsp_data.offset == $past(req_data.addr[27:0])) else $error("offset keeps alias bit");
   secure_flag_a: assert property (
      req_data.valid |=> rsp_data.tgt == TGT_NONE ||
      rsp_data.secure == $past(req_data.addr[28])) else $error("secure flag wrong");
   data_wins_a: assert property (
      req_data.valid |=> rsp_data.valid && !rsp_data.stall) else $error("data bus not served");
   slot_index_a: assert property (
      rsp_data.tgt == TGT_LSP |-> rsp_data.slot == rsp_data.offset[17:12] &&
      rsp_data.offset < 28'h0040000) else $error("slot index wrong");
   data_unmapped_a: assert property (
      req_data.valid && req_data.addr[31:29] == 3'h0 |=>
      rsp_data.resp == RESP_ERROR && rsp_data.tgt == TGT_NONE) else $error("no fault");
   dsp_no_fault_a: assert property (
      req_dsp.valid && !req_dsp.nonsec && req_dsp.addr[31:29] > 3'h2 &&
      perm_dsp[req_dsp.addr[RANGE_LSB+4:RANGE_LSB]] == PERM_OPEN |=>
      rsp_dsp.resp == RESP_OKAY) else $error("dsp faulted");
   closed_deny_a: assert property (
      req_code.valid && perm_code[req_code.addr[RANGE_LSB+4:RANGE_LSB]] == PERM_CLOSED |=>
      rsp_code.valid && rsp_code.resp == RESP_ERROR) else $error("closed range passed");
   dsp_bypass_a: assert property (
      rsp_dsp.valid && rsp_dsp.tgt == TGT_RAM |-> rsp_dsp.bypass) else $error("no bypass");
   stall_cause_a: assert property (
      rsp_code.stall |-> rsp_data.valid && rsp_data.tgt != TGT_NONE) else $error("bad stall");
endmodule
`default_nettype wire

// ---- test/sad_master_model.sv ----
// bus master model: holds a request until the decoder answers it
`default_nettype none
module sad_master_model
   import sad_pkg::*;
(
   input  wire logic     sys_clk, // system clock
   input  wire sad_rsp_t rsp,     // answer from the decoder
   output var  sad_req_t req      // request to the decoder
);
   timeunit 1ns;
   timeprecision 1ns;
   initial req = '0;
   // retries while stalled; released lines show inverted values
   task automatic issue(input logic [31:0] a, input logic ns, input logic ins,
                        output sad_rsp_t r, output int stalls, input logic wr = 1'b0);
      stalls = 0;
      @(posedge sys_clk);
      #1;
      req = '{valid: 1'b1, addr: a, write: wr, nonsec: ns, instr: ins};
      do begin
         @(posedge sys_clk);
         #1;
         r = rsp;
         stalls++;
      end while (r.stall === 1'b1 && stalls < 8);
      stalls--;
      req = '{valid: 1'b0, addr: ~a, write: ~wr, nonsec: ~ns, instr: ~ins};
   endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the address decoder
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import sad_pkg::*;
   logic                   sys_clk, resetn;
   sad_req_t               req_data, req_code, req_dsp;
   sad_perm_t [RANGES-1:0] perm_data, perm_code, perm_dsp;
   sad_rsp_t               rsp_data, rsp_code, rsp_dsp, r, r2;
   int                     fail_count, n_checks, st, st2;

   sad_decoder u_dut (.sys_clk(sys_clk), .resetn(resetn), .req_data(req_data),
      .req_code(req_code), .req_dsp(req_dsp), .perm_data(perm_data), .perm_code(perm_code),
      .perm_dsp(perm_dsp), .rsp_data(rsp_data), .rsp_code(rsp_code), .rsp_dsp(rsp_dsp));
   sad_master_model m_data (.sys_clk(sys_clk), .rsp(rsp_data), .req(req_data));
   sad_master_model m_code (.sys_clk(sys_clk), .rsp(rsp_code), .req(req_code));
   sad_master_model m_dsp (.sys_clk(sys_clk), .rsp(rsp_dsp), .req(req_dsp));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one secure-side request on master m, answer compared, offset and secure only for a mapped target
   task automatic go(input int m, input logic [31:0] a, input sad_tgt_t t,
                     input sad_resp_t e = RESP_OKAY, input logic [2:0] p = 3'h0,
                     input logic [5:0] s = 6'h00);
      case (m)
         0: m_data.issue(a, 1'b0, 1'b0, r, st);
         1: m_code.issue(a, 1'b0, 1'b1, r, st);
         default: m_dsp.issue(a, 1'b0, 1'b0, r, st);
      endcase
      check(r.valid, 1'b1);
      check(r.tgt, t);
      check(r.resp, e);
      check(r.ram_port, p);
      check(r.slot, s);
      check(r.bypass, m == 2 && t == TGT_RAM);
      if (t != TGT_NONE) begin
         check(r.offset, a[27:0]);
         check(r.secure, a[28]);
      end
   endtask

   task automatic t_code;
      go(1, 32'h0000_0010, TGT_RAM);
      go(1, 32'h1000_FFFF, TGT_RAM);
      go(1, 32'h0001_0000, TGT_RAM, RESP_OKAY, 3'h1);
      go(1, 32'h1002_0000, TGT_RAM, RESP_OKAY, 3'h2);
      go(1, 32'h0004_0000, TGT_RAM, RESP_OKAY, 3'h3);
      go(1, 32'h0008_0000, TGT_RAM, RESP_OKAY, 3'h4);
      go(1, 32'h1010_0000, TGT_RAM, RESP_OKAY, 3'h5);
      go(1, 32'h0047_FFFF, TGT_RAM, RESP_OKAY, 3'h6);
      go(1, 32'h0300_0000, TGT_ROM);
      go(1, 32'h1303_FFFF, TGT_ROM);
      go(1, 32'h0800_0000, TGT_FLASH);
      go(1, 32'h1FFF_FFFF, TGT_FLASH);
      go(1, 32'h0048_0000, TGT_NONE, RESP_ERROR);
      go(1, 32'h2000_0000, TGT_NONE, RESP_ERROR);
      $display("code bus map done");
   endtask

   task automatic t_data;
      go(0, 32'h2000_0000, TGT_RAM);
      go(0, 32'h3047_FFFF, TGT_RAM, RESP_OKAY, 3'h6);
      go(0, 32'h2400_0000, TGT_DTCM);
      go(0, 32'h3402_FFFF, TGT_ITCM);
      go(0, 32'h2401_0000, TGT_NONE, RESP_ERROR);
      go(0, 32'h2800_0000, TGT_NONE, RESP_ERROR);
      go(0, 32'h4000_0000, TGT_LSP);
      go(0, 32'h5003_FFFF, TGT_LSP, RESP_OKAY, 3'h0, 6'h3F);
      go(0, 32'h4000_5000, TGT_LSP, RESP_OKAY, 3'h0, 6'h05);
      go(0, 32'h4004_0000, TGT_NONE, RESP_ERROR);
      go(0, 32'h4010_0000, TGT_HSP);
      go(0, 32'h5015_FFFF, TGT_HSP);
      go(0, 32'h0000_0010, TGT_NONE, RESP_ERROR);
      $display("data bus map done");
   endtask

   task automatic t_dsp;
      go(2, 32'h2000_0010, TGT_RAM);
      go(2, 32'h2800_0000, TGT_FLASH_NC);
      go(2, 32'h0300_0000, TGT_NONE);
      go(2, 32'h4005_0000, TGT_NONE);
      go(2, 32'h6000_0000, TGT_NONE);
      $display("dsp map done");
   endtask

   task automatic t_conc;
      fork
         m_data.issue(32'h2001_0000, 1'b0, 1'b0, r, st);
         m_code.issue(32'h0000_0010, 1'b0, 1'b1, r2, st2);
      join
      check(st + st2, 0);
      fork
         m_data.issue(32'h2000_0010, 1'b0, 1'b0, r, st);
         m_code.issue(32'h1000_0010, 1'b0, 1'b1, r2, st2);
      join
      check(st2, 1);
      check(r2.tgt, TGT_RAM);
      fork
         m_data.issue(32'h2000_0010, 1'b0, 1'b0, r, st);
         m_dsp.issue(32'h2000_0020, 1'b0, 1'b0, r2, st2);
      join
      check(st2, 0);
      fork
         m_data.issue(32'h4010_0000, 1'b0, 1'b0, r, st);
         m_dsp.issue(32'h4010_0100, 1'b0, 1'b0, r2, st2);
      join
      check(st2, 1);
      $display("concurrency done");
   endtask

   task automatic t_perm;
      logic ok;
      for (int p = 0; p < 4; p++) begin
         for (int n = 0; n < 2; n++) begin
            perm_code[0] = sad_perm_t'(p);
            ok = (p < 2 && n == 0) || p == 2;
            m_code.issue(32'h1000_0010, n[0], 1'b1, r, st);
            check(r.resp, ok ? RESP_OKAY : RESP_ERROR);
            check(r.tgt, ok ? TGT_RAM : TGT_NONE);
         end
      end
      // callable area: a non-secure write or data read stays refused
      perm_code[0] = PERM_NSC;
      m_code.issue(32'h1000_0010, 1'b1, 1'b1, r, st, 1'b1);
      check(r.resp, RESP_ERROR);
      m_code.issue(32'h1000_0010, 1'b1, 1'b0, r, st);
      check(r.resp, RESP_ERROR);
      perm_code[0] = PERM_OPEN;
      // open range: non-secure requester on the non-secure alias passes
      m_code.issue(32'h0000_0010, 1'b1, 1'b1, r, st);
      check(r.resp, RESP_OKAY);
      check(r.tgt, TGT_RAM);
      $display("checker permissions done");
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   initial begin
      resetn = 1'b0;
      perm_data = '{default: PERM_OPEN};
      perm_code = '{default: PERM_OPEN};
      perm_dsp = '{default: PERM_OPEN};
      fail_count = 0;
      n_checks = 0;
      repeat (10) @(posedge sys_clk);
      #1 resetn = 1'b1;
      t_code;
      t_data;
      t_dsp;
      t_conc;
      t_perm;
      report_and_stop;
   end

   initial begin
      #200000;
      fail_count++;
      report_and_stop;
   end
endmodule

bind sad_decoder sad_decoder_asserts #(.RANGE_LSB(RANGE_LSB)) u_asserts (
   .sys_clk(sys_clk), .resetn(resetn), .req_data(req_data), .req_code(req_code),
   .req_dsp(req_dsp), .perm_data(perm_data), .perm_code(perm_code), .perm_dsp(perm_dsp),
   .rsp_data(rsp_data), .rsp_code(rsp_code), .rsp_dsp(rsp_dsp));
`default_nettype wire
